// ### hdl/adcm_pkg.sv
package adcm_pkg;
  localparam logic [3:0] OFF_INPUT_SELECT = 4'h0;
  localparam logic [3:0] OFF_CONTROL_A = 4'h4;
  localparam logic [3:0] OFF_CONTROL_B = 4'h8;
  localparam logic [3:0] OFF_RESULT = 4'hC;
  localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
  localparam logic [7:0] RST_CONTROL_A = 8'h00;
  localparam logic [7:0] RST_CONTROL_B = 8'h00;
  localparam int REF_LSB = 6;
  localparam int ALIGN_BIT = 5;
  localparam int CHAN_LSB = 0;
  localparam int ENABLE_BIT = 7;
  localparam int START_BIT = 6;
  localparam int AUTO_BIT = 5;
  localparam int FLAG_BIT = 4;
  localparam int IE_BIT = 3;
  localparam int DIV_LSB = 0;
  localparam int TRIG_LSB = 0;
  localparam logic [1:0] REF_INTERNAL = 2'h3;
  localparam logic [4:0] FIRST_CYCLES = 5'h19;
  localparam logic [4:0] NORMAL_CYCLES = 5'h0D;
  localparam logic [4:0] CHAN_BANDGAP = 5'h1E;
  localparam logic [4:0] CHAN_GROUND = 5'h1F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {GAIN_1X, GAIN_10X, GAIN_200X} adcm_gain_e;
  typedef enum logic {ST_IDLE, ST_CONV} adcm_state_e;

  typedef struct packed {
    logic diff;
    logic [2:0] pos;
    logic [2:0] neg;
    logic bandgap;
    logic ground;
    adcm_gain_e gain;
  } adcm_route_s;

  typedef struct packed {
    logic power;
    logic start;
    logic first;
    logic tick;
    logic [1:0] ref_sel;
    logic int_ref_on;
    adcm_route_s route;
  } adcm_core_s;
endpackage : adcm_pkg

// ### hdl/adcm_route_decode.sv
`timescale 1ns/100ps
module adcm_route_decode (
  input wire logic [4:0] chan,
  output adcm_pkg::adcm_route_s route
);
  always_comb begin
    route = '0;
    route.gain = adcm_pkg::GAIN_1X;
    if (chan == adcm_pkg::CHAN_BANDGAP) begin
      route.bandgap = 1'b1;
    end else if (chan == adcm_pkg::CHAN_GROUND) begin
      route.ground = 1'b1;
    end else if (chan[4:3] == 2'b00) begin
      route.pos = chan[2:0];
    end else if (chan[4:3] == 2'b01) begin
      route.diff = 1'b1;
      route.neg = chan[2] ? 3'h2 : 3'h0;
      // Even codes short the negative input onto itself
      route.pos = chan[0] ? (route.neg + 3'h1) : route.neg;
      route.gain = chan[1] ? adcm_pkg::GAIN_200X : adcm_pkg::GAIN_10X;
    end else begin
      route.diff = 1'b1;
      route.pos = chan[2:0];
      route.neg = chan[3] ? 3'h2 : 3'h1;
    end
  end
endmodule : adcm_route_decode

// ### hdl/adcm_top.sv
`timescale 1ns/100ps
// Function
// - reference field picks pin, supply or internal
// - reference and channel changes wait for completion
// - alignment bit left or right adjusts result
// - alignment change remaps result view immediately
// - channel codes select single inputs, bandgap, ground
// - codes 01xxx select gain-stage differential pairs
// - codes 1xxxx below 30 select unity-gain differential pairs
// - enable powers up; clearing aborts conversion
// - start bit launches single or first free-run
// - first conversion 25 cycles, later 13
// - start reads one while busy; zero ignored
// - auto-trigger starts on selected source edge
// - done flag sets with result update
// - interrupt while flag, enable, global enable
// - flag cleared by vector acknowledge or one
// - divider codes give 2 up to 128
// - interrupt enable bit gates the interrupt
// - selection switch from clear to set source triggers
module adcm_top #(
  parameter int ADDR_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] trigger_sources,
  input wire logic cpu_global_irq_enable,
  input wire logic irq_vector_ack,
  input wire logic [9:0] adc_result_in,
  output adcm_pkg::adcm_core_s core_ctrl,
  output logic conversion_done_irq
);
  if (ADDR_W < 4) begin : g_chk
    $error("ADDR_W must be at least 4");
  end
  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic next_aw_held, next_w_held, next_awready, next_wready, next_bvalid;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [7:0] next_w_byte;
  logic next_w_lane0;
  logic [1:0] next_bresp, next_rresp;
  logic next_arready, next_rvalid;
  logic [31:0] next_rdata;
  logic [7:0] input_select, ctrl_b, next_input_select, next_ctrl_b;
  logic enable, auto_trig, flag, irq_en, init_pending;
  logic [2:0] divider;
  logic next_enable, next_auto_trig, next_flag, next_irq_en, next_init_pending;
  logic [2:0] next_divider;
  adcm_pkg::adcm_state_e state, next_state;
  logic [6:0] pcnt, next_pcnt;
  logic [4:0] ccnt, next_ccnt, conv_len, next_conv_len;
  logic [9:0] result, next_result;
  logic [7:0] active_sel, next_active_sel;
  logic trig_prev, next_trig_prev;
  adcm_pkg::adcm_core_s next_core;
  logic next_irq;
  adcm_pkg::adcm_route_s route;
  logic wr_fire, wr_map, wr_isel, wr_ca, wr_cb;
  logic [6:0] div_max;
  logic tick, done, trig_level, trig_edge, start_now, first_now, free_run;
  logic [15:0] result_view;
  adcm_route_decode u_decode (
    .chan(next_active_sel[4:0]),
    .route(route)
  );
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_map = aw_addr[3:0] == adcm_pkg::OFF_INPUT_SELECT
               || aw_addr[3:0] == adcm_pkg::OFF_CONTROL_A
               || aw_addr[3:0] == adcm_pkg::OFF_CONTROL_B
               || aw_addr[3:0] == adcm_pkg::OFF_RESULT;
  assign wr_isel = wr_fire && w_lane0 && aw_addr[3:0] == adcm_pkg::OFF_INPUT_SELECT;
  assign wr_ca = wr_fire && w_lane0 && aw_addr[3:0] == adcm_pkg::OFF_CONTROL_A;
  assign wr_cb = wr_fire && w_lane0 && aw_addr[3:0] == adcm_pkg::OFF_CONTROL_B;
  // Divisor 2 for codes 0 and 1, doubling above
  assign div_max = (divider < 3'h2) ? 7'h01 : 7'((8'h01 << divider) - 8'h01);
  assign tick = (state == adcm_pkg::ST_CONV) && (pcnt == div_max);
  assign done = tick && (ccnt == conv_len - 5'h01) && enable;

  // Source 0 is free running and never yields a level, so never an edge
  assign trig_level = (ctrl_b[2:0] == 3'h0) ? 1'b0 : trigger_sources[ctrl_b[2:0]];
  assign trig_edge = trig_level && !trig_prev;
  assign free_run = auto_trig && ctrl_b[2:0] == 3'h0;

  // Left view places the ten bits at the top of sixteen
  assign result_view = input_select[adcm_pkg::ALIGN_BIT] ? {result, 6'h00}
                                                       : {6'h00, result};

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_map ? adcm_pkg::RESP_OKAY : adcm_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = adcm_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case (s_axi_araddr[3:0])
        adcm_pkg::OFF_INPUT_SELECT: next_rdata[7:0] = input_select;
        adcm_pkg::OFF_CONTROL_A: next_rdata[7:0] = {enable, state == adcm_pkg::ST_CONV,
                                               auto_trig, flag, irq_en, divider};
        adcm_pkg::OFF_CONTROL_B: next_rdata[7:0] = ctrl_b;
        adcm_pkg::OFF_RESULT: next_rdata[15:0] = result_view;
        default: next_rresp = adcm_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (ce) begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  always_comb begin
    next_input_select = wr_isel ? w_byte : input_select;
    next_ctrl_b = wr_cb ? {5'h00, w_byte[2:0]} : ctrl_b;
    next_enable = wr_ca ? w_byte[adcm_pkg::ENABLE_BIT] : enable;
    next_auto_trig = wr_ca ? w_byte[adcm_pkg::AUTO_BIT] : auto_trig;
    next_irq_en = wr_ca ? w_byte[adcm_pkg::IE_BIT] : irq_en;
    next_divider = wr_ca ? w_byte[2:0] : divider;
    next_trig_prev = trig_level;
    next_state = state;
    next_pcnt = pcnt;
    next_ccnt = ccnt;
    next_conv_len = conv_len;
    next_result = result;
    next_init_pending = init_pending || (next_enable && !enable);
    first_now = next_init_pending;
    // Start bit written as zero is simply not looked at
    start_now = 1'b0;
    if (next_enable && state == adcm_pkg::ST_IDLE) begin
      start_now = (wr_ca && w_byte[adcm_pkg::START_BIT])
               || (auto_trig && trig_edge);
    end
    if (done && free_run && next_enable) begin
      start_now = 1'b1;
    end
    if (tick) begin
      next_pcnt = 7'h00;
      next_ccnt = ccnt + 5'h01;
    end else if (state == adcm_pkg::ST_CONV) begin
      next_pcnt = pcnt + 7'h01;
    end
    if (done) begin
      next_result = adc_result_in;
      next_state = adcm_pkg::ST_IDLE;
    end
    if (start_now) begin
      next_state = adcm_pkg::ST_CONV;
      next_pcnt = 7'h00;
      next_ccnt = 5'h00;
      next_conv_len = first_now ? adcm_pkg::FIRST_CYCLES : adcm_pkg::NORMAL_CYCLES;
      next_init_pending = 1'b0;
    end
    if (!next_enable) begin
      next_state = adcm_pkg::ST_IDLE;
      next_init_pending = 1'b0;
    end
    // Selections track the register only between conversions
    next_active_sel = (next_state == adcm_pkg::ST_IDLE || start_now)
                    ? next_input_select : active_sel;
    next_flag = flag;
    if (irq_vector_ack || (wr_ca && w_byte[adcm_pkg::FLAG_BIT])) begin
      next_flag = 1'b0;
    end
    if (done) begin
      next_flag = 1'b1;
    end
    next_irq = next_flag && next_irq_en && cpu_global_irq_enable;
    next_core.power = next_enable;
    next_core.start = start_now;
    next_core.first = start_now && first_now;
    next_core.tick = tick;
    next_core.ref_sel = next_active_sel[7:6];
    next_core.int_ref_on = next_active_sel[7:6] == adcm_pkg::REF_INTERNAL;
    next_core.route = route;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_select <= adcm_pkg::RST_INPUT_SELECT;
      ctrl_b <= adcm_pkg::RST_CONTROL_B;
      enable <= adcm_pkg::RST_CONTROL_A[adcm_pkg::ENABLE_BIT];
      auto_trig <= adcm_pkg::RST_CONTROL_A[adcm_pkg::AUTO_BIT];
      flag <= adcm_pkg::RST_CONTROL_A[adcm_pkg::FLAG_BIT];
      irq_en <= adcm_pkg::RST_CONTROL_A[adcm_pkg::IE_BIT];
      divider <= adcm_pkg::RST_CONTROL_A[2:0];
      init_pending <= 1'b0;
      state <= adcm_pkg::ST_IDLE;
      pcnt <= 7'h00;
      ccnt <= 5'h00;
      conv_len <= adcm_pkg::NORMAL_CYCLES;
      result <= 10'h000;
      active_sel <= adcm_pkg::RST_INPUT_SELECT;
      trig_prev <= 1'b0;
      core_ctrl <= '0;
      conversion_done_irq <= 1'b0;
    end else if (ce) begin
      input_select <= next_input_select;
      ctrl_b <= next_ctrl_b;
      enable <= next_enable;
      auto_trig <= next_auto_trig;
      flag <= next_flag;
      irq_en <= next_irq_en;
      divider <= next_divider;
      init_pending <= next_init_pending;
      state <= next_state;
      pcnt <= next_pcnt;
      ccnt <= next_ccnt;
      conv_len <= next_conv_len;
      result <= next_result;
      active_sel <= next_active_sel;
      trig_prev <= next_trig_prev;
      core_ctrl <= next_core;
      conversion_done_irq <= next_irq;
    end
  end

  // Tick count since start, read only by the checks below
  logic [4:0] ast_ticks;
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && start_now)) begin
      ast_ticks <= 5'h00;
    end else if (ce && tick) begin
      ast_ticks <= ast_ticks + 5'h01;
    end
  end

  default clocking cb @(posedge aclk iff ce);
  endclocking
  default disable iff (!aresetn);

  sequence seq_read_ctrl;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[3:0] == adcm_pkg::OFF_CONTROL_A;
  endsequence
  sequence seq_read_result;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[3:0] == adcm_pkg::OFF_RESULT;
  endsequence

  AST_HOLD_SEL: assert property ((state == adcm_pkg::ST_CONV && !done && next_enable)
    |=> active_sel == $past(active_sel)) else $error("selection changed mid conversion");
  AST_ALIGN_VIEW: assert property (seq_read_result |=> s_axi_rdata[15:0] ==
    ($past(input_select[5]) ? {$past(result), 6'h00} : {6'h00, $past(result)}))
    else $error("result view misaligned");
  AST_ABORT: assert property ($fell(enable) |-> !core_ctrl.power
    && state == adcm_pkg::ST_IDLE) else $error("disable did not abort");
  AST_CONV_LEN: assert property (done |-> ast_ticks + 5'h01 == conv_len
    && (conv_len == 5'h19 || conv_len == 5'h0D)) else $error("conversion length wrong");
  AST_START_READ: assert property (seq_read_ctrl |=> s_axi_rdata[6] ==
    ($past(state) == adcm_pkg::ST_CONV)) else $error("start bit readback wrong");
  AST_TRIG: assert property ((enable && auto_trig && trig_edge && state == adcm_pkg::ST_IDLE
    && !(wr_ca && !w_byte[7])) |=> state == adcm_pkg::ST_CONV && core_ctrl.start)
    else $error("trigger edge missed");
  AST_DONE: assert property (done |=> flag && result == $past(adc_result_in))
    else $error("completion not recorded");
  AST_IRQ: assert property (conversion_done_irq ==
    (flag && irq_en && $past(cpu_global_irq_enable))) else $error("interrupt request wrong");
  AST_FLAG_CLR: assert property ((irq_vector_ack && !done) |=> !flag)
    else $error("flag not cleared");
  AST_FREE_RUN: assert property ((done && free_run && next_enable)
    |=> state == adcm_pkg::ST_CONV && core_ctrl.start) else $error("free run stalled");
endmodule : adcm_top

// ### test/adcm_core_model.sv
`timescale 1ns/100ps
module adcm_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire adcm_pkg::adcm_core_s core_ctrl,
  input wire logic [9:0] next_result,
  output logic [9:0] adc_result_in
);
  logic [9:0] held;
  logic [9:0] next_held;

  // Value chosen by the bench is frozen at conversion start
  always_comb begin
    next_held = held;
    if (core_ctrl.start) begin
      next_held = next_result;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held <= 10'h000;
    end else begin
      held <= next_held;
    end
  end

  // Powered-down core floats; inverted value stops a stale match
  assign adc_result_in = core_ctrl.power ? held : ~held;
endmodule : adcm_core_model

// ### test/adcm_top_tb.sv
`timescale 1ns/100ps
module adcm_top_tb;
  typedef struct packed {
    logic [4:0] ch;
    logic [1:0] rf;
    logic al;
    logic [2:0] dv;
    logic df;
    logic [2:0] p;
    logic [2:0] n;
    logic [1:0] g;
    logic bg;
    logic gd;
  } adcm_row_s;

  // Channel, reference, alignment, divider, then expected route
  adcm_row_s rows [14] = '{
    '{3, 0, 0, 0, 0, 3, 0, 0, 0, 0}, '{7, 1, 1, 1, 0, 7, 0, 0, 0, 0},
    '{9, 3, 0, 2, 1, 1, 0, 1, 0, 0}, '{11, 3, 1, 3, 1, 1, 0, 2, 0, 0},
    '{13, 1, 0, 4, 1, 3, 2, 1, 0, 0}, '{15, 0, 1, 5, 1, 3, 2, 2, 0, 0},
    '{10, 1, 0, 6, 1, 0, 0, 2, 0, 0}, '{16, 3, 1, 7, 1, 0, 1, 0, 0, 0},
    '{23, 1, 0, 0, 1, 7, 1, 0, 0, 0}, '{24, 0, 1, 1, 1, 0, 2, 0, 0, 0},
    '{26, 3, 0, 2, 1, 2, 2, 0, 0, 0}, '{29, 1, 1, 3, 1, 5, 2, 0, 0, 0},
    '{30, 3, 0, 0, 0, 0, 0, 0, 1, 0}, '{31, 0, 0, 0, 0, 0, 0, 0, 0, 1}};

  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, gie = 1'b1, ack = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [7:0] trig = 8'h00;
  logic [9:0] next_res = 10'h000, res_in;
  logic awready, wready, bvalid, arready, rvalid, irq, irq_d, rint, fst;
  logic [1:0] bresp, rresp, rref;
  logic [31:0] rdata;
  adcm_pkg::adcm_core_s cc;
  adcm_pkg::adcm_route_s rt;
  int fails = 0, n_compared = 0, nst = 0, tcnt = 0, gcnt = 0, ticks = 0, gap = 0;

  initial begin
    forever #25 aclk = ~aclk;
  end

  adcm_top DUT (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trigger_sources(trig), .cpu_global_irq_enable(gie), .irq_vector_ack(ack),
    .adc_result_in(res_in), .core_ctrl(cc), .conversion_done_irq(irq)
  );

  adcm_core_model core (
    .aclk(aclk), .aresetn(aresetn), .core_ctrl(cc), .next_result(next_res),
    .adc_result_in(res_in)
  );

  // Tick count per conversion, tick spacing and the route held mid-conversion
  always @(posedge aclk) begin
    irq_d <= irq;
    gcnt <= cc.tick ? 1 : gcnt + 1;
    if (cc.tick) gap <= gcnt;
    if (cc.start) nst <= nst + 1;
    if (cc.start) fst <= cc.first;
    tcnt <= cc.start ? 0 : tcnt + int'(cc.tick);
    // Last tick and the interrupt arrive together
    if (irq && !irq_d) ticks <= tcnt + int'(cc.tick);
    if (cc.tick && tcnt == 1) begin
      rt <= cc.route;
      rref <= cc.ref_sel;
      rint <= cc.int_ref_on;
    end
  end

  task automatic results;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic tmo;
    fails++;
    results();
  endtask : tmo

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  // Whole-byte writes only: no read-modify-write of control A
  task automatic axw(input logic [3:0] a, input logic [7:0] d);
    int i;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk("bresp", adcm_pkg::RESP_OKAY, bresp);
    // Idle edge so the next call never reassigns in this step
    @(posedge aclk);
    if (i == 200) tmo();
  endtask : axw

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    @(posedge aclk);
    if (i == 200) tmo();
  endtask : axr

  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(nm, e, d);
    chk("rresp", adcm_pkg::RESP_OKAY, r);
  endtask : rdc

  task automatic wait_irq;
    int i;
    for (i = 0; i < 5000; i++) begin
      @(posedge aclk);
      if (irq === 1'b1) break;
    end
    if (i == 5000) tmo();
  endtask : wait_irq

  initial begin
    int i;
    int s;
    logic [31:0] d;
    logic [1:0] r;
    logic [9:0] pr;
    adcm_row_s w;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 14; i++) begin
      w = rows[i];
      next_res <= 10'h2a5 ^ 10'(i * 37);
      axw(adcm_pkg::OFF_INPUT_SELECT, {w.rf, w.al, w.ch});
      axw(adcm_pkg::OFF_CONTROL_A, {5'h1b, w.dv});
      wait_irq();
      rdc("input_select", adcm_pkg::OFF_INPUT_SELECT, {24'h00_0000, w.rf, w.al, w.ch});
      rdc("control_a", adcm_pkg::OFF_CONTROL_A, {24'h00_0000, 5'h13, w.dv});
      rdc("result", adcm_pkg::OFF_RESULT,
          w.al ? {16'h0000, next_res, 6'h00} : {22'h00_0000, next_res});
      chk("ticks", i == 0 ? 25 : 13, ticks);
      chk("first", i == 0, fst);
      chk("tick_gap", w.dv == 0 ? 2 : 1 << w.dv, gap);
      chk("ref_sel", w.rf, rref);
      chk("int_ref_on", w.rf == 2'h3, rint);
      chk("diff", w.df, rt.diff);
      chk("bandgap", w.bg, rt.bandgap);
      chk("ground", w.gd, rt.ground);
      if (!w.bg && !w.gd) chk("pos", w.p, rt.pos);
      if (w.df) chk("neg", w.n, rt.neg);
      if (w.df) chk("gain", w.g, rt.gain);
    end
    pr = next_res;
    axw(adcm_pkg::OFF_INPUT_SELECT, 8'h03);
    axw(adcm_pkg::OFF_CONTROL_A, 8'hd8);
    axw(adcm_pkg::OFF_INPUT_SELECT, 8'h25);
    rdc("busy", adcm_pkg::OFF_CONTROL_A, 32'h0000_00c8);
    rdc("realign", adcm_pkg::OFF_RESULT, {16'h0000, pr, 6'h00});
    chk("pos_held", 3, cc.route.pos);
    wait_irq();
    axw(adcm_pkg::OFF_CONTROL_A, 8'hd8);
    wait_irq();
    chk("pos_next", 5, rt.pos);
    s = nst;
    axw(adcm_pkg::OFF_CONTROL_A, 8'h88);
    repeat (60) @(posedge aclk);
    chk("zero_start", s, nst);
    gie <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("irq_gie_off", 0, irq);
    gie <= 1'b1;
    axw(adcm_pkg::OFF_CONTROL_A, 8'h80);
    repeat (3) @(posedge aclk);
    chk("irq_ie_off", 0, irq);
    axw(adcm_pkg::OFF_CONTROL_A, 8'h88);
    repeat (3) @(posedge aclk);
    chk("irq_on", 1, irq);
    ack <= 1'b1;
    @(posedge aclk);
    ack <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("irq_acked", 0, irq);
    rdc("flag_acked", adcm_pkg::OFF_CONTROL_A, 32'h0000_0088);
    axw(adcm_pkg::OFF_CONTROL_A, 8'hd8);
    repeat (10) @(posedge aclk);
    axw(adcm_pkg::OFF_CONTROL_A, 8'h08);
    repeat (100) @(posedge aclk);
    chk("power_off", 0, cc.power);
    rdc("aborted", adcm_pkg::OFF_CONTROL_A, 32'h0000_0008);
    axw(adcm_pkg::OFF_CONTROL_A, 8'hd8);
    wait_irq();
    @(posedge aclk);
    chk("ticks_reenable", 25, ticks);
    chk("first_reenable", 1, fst);
    axw(adcm_pkg::OFF_CONTROL_B, 8'h02);
    axw(adcm_pkg::OFF_CONTROL_A, 8'hb8);
    s = nst;
    trig[2] <= 1'b1;
    wait_irq();
    chk("trig_edge", s + 1, nst);
    axw(adcm_pkg::OFF_CONTROL_A, 8'hb8);
    // Old source cleared, new one set: the switch itself is the edge
    trig <= 8'h08;
    axw(adcm_pkg::OFF_CONTROL_B, 8'h03);
    wait_irq();
    chk("trig_switch", s + 2, nst);
    axw(adcm_pkg::OFF_CONTROL_B, 8'h00);
    repeat (60) @(posedge aclk);
    chk("free_no_trig", s + 2, nst);
    axw(adcm_pkg::OFF_CONTROL_A, 8'hf8);
    repeat (300) @(posedge aclk);
    chk("free_run", 1, nst > s + 4);
    axw(adcm_pkg::OFF_CONTROL_B, 8'h05);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc("rst_input", adcm_pkg::OFF_INPUT_SELECT, 32'h0000_0000);
    rdc("rst_ctrl_a", adcm_pkg::OFF_CONTROL_A, 32'h0000_0000);
    rdc("rst_ctrl_b", adcm_pkg::OFF_CONTROL_B, 32'h0000_0000);
    axr(4'h1, d, r);
    chk("unmapped", adcm_pkg::RESP_SLVERR, r);
    results();
  end
endmodule : adcm_top_tb
